// File: logic/test_session_pkg.sv
// constants, field layouts and states for the test session control block
// assumes a single 100 MHz clock domain
package test_session_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SECOND_NS       = 1_000_000_000;
  localparam int unsigned CLK_PERIOD_NS   = SECOND_NS / CLK_HZ;
  localparam int unsigned SECOND_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned SECONDS_PER_MIN = 60;

  localparam logic [10:0] TIMEOUT_MAX     = 11'h5A0;
  localparam logic [10:0] TIMEOUT_DEFAULT = 11'h03C;
  localparam logic [10:0] TIMEOUT_OFF     = 11'h000;
  localparam logic [19:0] ELAPSED_MAX     = 20'hF423F;

  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_ERR_SEC = 8'h0C;
  localparam logic [7:0] ADDR_EF_SEC  = 8'h10;
  localparam logic [7:0] ADDR_TIME    = 8'h14;

  // control word fields
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_FRAMED   = 4;
  localparam int unsigned CTL_START    = 8;
  localparam int unsigned CTL_STOP     = 9;

  // status word fields
  localparam int unsigned ST_MEAS_LSB  = 0;
  localparam int unsigned ST_WAIT      = 2;
  localparam int unsigned ST_DATA_NA   = 3;
  localparam int unsigned ST_VALID     = 4;
  localparam int unsigned ST_THROUGH   = 5;
  localparam int unsigned ST_MODE_LSB  = 8;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    MODE_DISABLED                = 3'h0,
    MODE_MONITOR_EQUIPMENT_SIDE  = 3'h1,
    MODE_MONITOR_FACILITY_SIDE   = 3'h2,
    MODE_LOOPBACK_EQUIPMENT_SIDE = 3'h3,
    MODE_LOOPBACK_FACILITY_SIDE  = 3'h4,
    MODE_SPLIT                   = 3'h5
  } access_mode_e;

  // gray sequence stopped -> waiting -> measurement_active_state
  typedef enum logic [1:0] {
    MEAS_STOPPED                  = 2'h0,
    MEAS_WAITING                  = 2'h1,
    MEASUREMENT_ACTIVE_STATE      = 2'h3
  } meas_state_e;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } bus_req_s;

  typedef struct packed {
    logic        frame_sync;
    logic        pattern_sync;
    logic        bit_error;
  } line_status_s;

endpackage : test_session_pkg

// File: logic/test_session_ctrl.sv
// test access session control: timeout, measurement sequencer, elapsed time
// assumes an AHB-Lite master on clk_sys and synchronous line status inputs
//
// Operation
// - errored and error-free second counters, six decimal digits, blank if none
// - timeout setting in minutes 0..1440, default 60 after reset
// - nonzero timeout reaching zero during test forces mode to disabled
// - timeout setting zero switches the timeout off
// - in split mode start waits for pattern sync, plus frame sync for framed patterns
// - once synchronised the measurement state shows measurement_active_state
// - stop request ends the measurement; default is stopped
// - monitor and loopback modes need frame sync only
// - data error count reads not applicable while measuring and pattern sync absent
// - selecting disabled mode ends the measurement like a stop
// - waiting-on-sync only while start pending and sync missing
// - disabled mode ends session, circuit passes through; default disabled
`timescale 1ns/1ps
`default_nettype none

module test_session_ctrl
  import test_session_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SECOND_CYCLES
)(
  input  wire  logic          clk_sys,
  input  wire  logic          reset,
  input  wire  logic          hsel,
  input  wire  logic [31:0]   haddr,
  input  wire  logic [1:0]    htrans,
  input  wire  logic          hwrite,
  input  wire  logic [2:0]    hsize,
  input  wire  logic [31:0]   hwdata,
  input  wire  logic          hready,
  output logic [31:0]         hrdata,
  output logic                hreadyout,
  output logic                hresp,
  input  wire  line_status_s  line_status,
  output logic                through_transmission,
  output logic [2:0]          access_mode,
  output logic                measuring
);

  bus_req_s     req_r;
  access_mode_e mode_r;
  logic         framed_r;
  logic [10:0]  timeout_set_r;
  logic [10:0]  timeout_cnt_r;
  logic         timeout_armed_r;
  meas_state_e  meas_r;
  meas_state_e  meas_nxt;
  logic [19:0]  err_sec_r;
  logic [19:0]  ef_sec_r;
  logic         counts_valid_r;
  logic         sec_err_r;
  logic [31:0]  sec_div_r;
  logic [5:0]   min_div_r;
  logic [31:0]  rdata_r;
  logic         sec_tick;
  logic         min_tick;
  logic         wr_ctl;
  logic         wr_tmo;
  logic         start_req;
  logic         stop_req;
  logic         start_ok;
  logic         disable_now;
  logic         sync_ok;
  logic         need_frame_only;
  logic         timeout_fire;
  access_mode_e mode_wr;

  // bus slave: always zero wait, OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      req_r <= '0;
    else if (hready)
      req_r <= '{sel: hsel && (htrans == HTRANS_NONSEQ),
                 write: hwrite, addr: haddr[7:0]};
  end

  assign wr_ctl    = req_r.sel && req_r.write && (req_r.addr == ADDR_CONTROL);
  assign wr_tmo    = req_r.sel && req_r.write && (req_r.addr == ADDR_TIMEOUT);
  assign mode_wr   = access_mode_e'(hwdata[CTL_MODE_LSB +: 3]);
  assign start_req = wr_ctl && hwdata[CTL_START];
  assign stop_req  = wr_ctl && hwdata[CTL_STOP];

  // second and minute strobes
  assign sec_tick = (sec_div_r == SEC_CYCLES - 1);
  assign min_tick = sec_tick && (min_div_r == 6'(SECONDS_PER_MIN - 1));

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sec_div_r <= '0;
      min_div_r <= '0;
    end
    else
    begin
      sec_div_r <= sec_tick ? '0 : sec_div_r + 32'h1;
      if (sec_tick)
        min_div_r <= min_tick ? '0 : min_div_r + 6'h1;
    end
  end

  // timeout setting, out-of-range writes clamp to the maximum
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      timeout_set_r <= TIMEOUT_DEFAULT;
    else if (wr_tmo)
      timeout_set_r <= (hwdata[10:0] > TIMEOUT_MAX || hwdata[31:11] != '0)
                       ? TIMEOUT_MAX : hwdata[10:0];
  end

  assign timeout_fire = timeout_armed_r && (mode_r != MODE_DISABLED)
                        && (timeout_cnt_r == 11'h001) && min_tick;

  // out-of-range mode codes land in disabled, so they stop as well
  assign disable_now = timeout_fire
                       || (wr_ctl && (mode_wr == MODE_DISABLED
                                      || mode_wr > MODE_SPLIT));

  assign start_ok = start_req && !stop_req && !disable_now;

  // access mode; session begins on leaving disabled
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      mode_r   <= MODE_DISABLED;
      framed_r <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        mode_r   <= (mode_wr > MODE_SPLIT) ? MODE_DISABLED : mode_wr;
        framed_r <= hwdata[CTL_FRAMED];
      end
      if (timeout_fire)
        mode_r <= MODE_DISABLED;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      timeout_cnt_r   <= TIMEOUT_OFF;
      timeout_armed_r <= 1'b0;
    end
    else if (wr_ctl && mode_r == MODE_DISABLED && mode_wr != MODE_DISABLED
             && mode_wr <= MODE_SPLIT)
    begin
      timeout_cnt_r   <= timeout_set_r;
      timeout_armed_r <= (timeout_set_r != TIMEOUT_OFF);
    end
    else if (timeout_fire || mode_r == MODE_DISABLED)
      timeout_armed_r <= 1'b0;
    else if (timeout_armed_r && min_tick)
      timeout_cnt_r <= timeout_cnt_r - 11'h001;
  end

  // sync needed before measuring
  assign need_frame_only = (mode_r == MODE_MONITOR_EQUIPMENT_SIDE)
                        || (mode_r == MODE_MONITOR_FACILITY_SIDE)
                        || (mode_r == MODE_LOOPBACK_EQUIPMENT_SIDE)
                        || (mode_r == MODE_LOOPBACK_FACILITY_SIDE);
  assign sync_ok = need_frame_only ? line_status.frame_sync
                 : (line_status.pattern_sync
                    && (!framed_r || line_status.frame_sync));

  always_comb
  begin
    meas_nxt = meas_r;
    case (meas_r)
      MEAS_STOPPED:
        if (start_ok)
          meas_nxt = MEAS_WAITING;
      MEAS_WAITING:
        if (sync_ok)
          meas_nxt = MEASUREMENT_ACTIVE_STATE;
      MEASUREMENT_ACTIVE_STATE:
        // a fresh start while measurement_active_state resyncs first
        if (start_ok)
          meas_nxt = MEAS_WAITING;
      default:
        meas_nxt = MEAS_STOPPED;
    endcase
    if (stop_req || disable_now)
      meas_nxt = MEAS_STOPPED;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      meas_r <= MEAS_STOPPED;
    else
      meas_r <= meas_nxt;
  end

  // elapsed time counters
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      err_sec_r      <= '0;
      ef_sec_r       <= '0;
      counts_valid_r <= 1'b0;
      sec_err_r      <= 1'b0;
    end
    else if (start_ok)
    begin
      err_sec_r      <= '0;
      ef_sec_r       <= '0;
      counts_valid_r <= 1'b0;
      sec_err_r      <= 1'b0;
    end
    else if (meas_r == MEASUREMENT_ACTIVE_STATE)
    begin
      counts_valid_r <= 1'b1;
      if (sec_tick)
      begin
        sec_err_r <= 1'b0;
        if (sec_err_r || line_status.bit_error)
        begin
          if (err_sec_r != ELAPSED_MAX)
            err_sec_r <= err_sec_r + 20'h1;
        end
        else if (ef_sec_r != ELAPSED_MAX)
          ef_sec_r <= ef_sec_r + 20'h1;
      end
      else if (line_status.bit_error)
        sec_err_r <= 1'b1;
    end
  end

  // read data
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      rdata_r <= '0;
    else if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite)
    begin
      case (haddr[7:0])
        ADDR_CONTROL: rdata_r <= {27'h0, framed_r, 1'b0, mode_r};
        ADDR_TIMEOUT: rdata_r <= {21'h0, timeout_set_r};
        ADDR_STATUS:
          rdata_r <= {21'h0, mode_r, 2'h0,
                      (mode_r == MODE_DISABLED),
                      counts_valid_r,
                      (meas_r == MEASUREMENT_ACTIVE_STATE
                       && !line_status.pattern_sync),
                      (meas_r == MEAS_WAITING),
                      meas_r};
        ADDR_ERR_SEC: rdata_r <= {12'h0, err_sec_r};
        ADDR_EF_SEC:  rdata_r <= {12'h0, ef_sec_r};
        ADDR_TIME:    rdata_r <= {20'h0, timeout_armed_r, timeout_cnt_r};
        default:      rdata_r <= '0;
      endcase
    end
  end

  assign through_transmission = (mode_r == MODE_DISABLED);
  assign access_mode          = mode_r;
  assign measuring            = (meas_r == MEASUREMENT_ACTIVE_STATE);

  a_timeout_disables: assert property (
    @(posedge clk_sys) disable iff (reset)
    timeout_fire |=> mode_r == MODE_DISABLED && meas_r == MEAS_STOPPED)
    else $error("timeout did not disable access");

  a_zero_never_fires: assert property (
    @(posedge clk_sys) disable iff (reset)
    !timeout_armed_r && !wr_ctl |=> $stable(mode_r))
    else $error("disarmed timeout fired");

  a_wait_gate: assert property (
    @(posedge clk_sys) disable iff (reset)
    meas_r == MEAS_WAITING && !sync_ok && !stop_req && !disable_now
    |=> meas_r == MEAS_WAITING)
    else $error("measurement started without sync");

  a_run_on_sync: assert property (
    @(posedge clk_sys) disable iff (reset)
    meas_r == MEAS_WAITING && sync_ok && !stop_req && !disable_now
    |=> measuring)
    else $error("sync reached but not measurement_active_state");

  a_stop_ends: assert property (
    @(posedge clk_sys) disable iff (reset)
    stop_req |=> meas_r == MEAS_STOPPED && !measuring)
    else $error("stop did not end measurement");

  a_disable_stops: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_ctl && mode_wr == MODE_DISABLED |=> meas_r == MEAS_STOPPED
    && through_transmission)
    else $error("disable did not stop measurement");

  a_clear_on_start: assert property (
    @(posedge clk_sys) disable iff (reset)
    start_ok
    |=> err_sec_r == '0 && ef_sec_r == '0 && !counts_valid_r)
    else $error("elapsed counters not cleared on start");

  a_hold_when_idle: assert property (
    @(posedge clk_sys) disable iff (reset)
    $past(meas_r) != MEASUREMENT_ACTIVE_STATE && !$past(start_ok)
    |-> $stable(err_sec_r) && $stable(ef_sec_r))
    else $error("elapsed counters moved while not measurement_active_state");

  a_reload_on_begin: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_ctl && mode_r == MODE_DISABLED && mode_wr != MODE_DISABLED
    && mode_wr <= MODE_SPLIT |=> timeout_cnt_r == $past(timeout_set_r))
    else $error("timeout not reloaded at session start");

endmodule : test_session_ctrl

`default_nettype wire

// File: verif/line_partner.sv
// tested circuit model: sync levels and periodic bit errors
// assumes bench commands arrive on clk_sys
`timescale 1ns/1ps
`default_nettype none
module line_partner
  import test_session_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        frame_en,
  input  wire logic        pattern_en,
  input  wire logic        err_en,
  output var  line_status_s line_status
);
  logic [1:0] ph_r;
  initial ph_r = 2'h0;
  // one error in four cycles while errors are commanded
  always_ff @(posedge clk_sys)
  begin
    ph_r                     <= ph_r + 2'h1;
    line_status.frame_sync   <= frame_en;
    line_status.pattern_sync <= pattern_en;
    line_status.bit_error    <= err_en && (ph_r == 2'h0);
  end
endmodule : line_partner
`default_nettype wire

// File: verif/tb_test_session_ctrl.sv
// bench for the test session control block
// assumes line_partner and a shortened second of 10 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  n_fail++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb_test_session_ctrl
  import test_session_pkg::*;
;
  logic         clk_sys, reset, hsel, hwrite, hready;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [1:0]   htrans;
  logic [2:0]   hsize, access_mode;
  logic         hresp, through_transmission, measuring;
  logic         frame_en, pattern_en, err_en;
  line_status_s line_status;
  int           n_fail, num_checks;

  test_session_ctrl #(.SEC_CYCLES(10)) uut (.clk_sys(clk_sys),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .line_status(line_status),
    .through_transmission(through_transmission),
    .access_mode(access_mode), .measuring(measuring));
  line_partner far (.clk_sys(clk_sys), .frame_en(frame_en),
    .pattern_en(pattern_en), .err_en(err_en), .line_status(line_status));

  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wait_meas(input logic v);
    for (int i = 0; i < 20 && measuring !== v; i++) @(posedge clk_sys);
  endtask : wait_meas

  task automatic reset_values;
    bus(ADDR_TIMEOUT, 1'b0, 32'h0);
    `CHK("timeout", 32'h0000003C, rd)
    bus(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("status", 32'h00000020, rd)
    `CHK("through", 1'b1, through_transmission)
    bus(ADDR_TIMEOUT, 1'b1, 32'h000007D0);
    bus(ADDR_TIMEOUT, 1'b0, 32'h0);
    `CHK("clamp", 32'h000005A0, rd)
  endtask : reset_values

  task automatic sync_gate;
    bus(ADDR_CONTROL, 1'b1, 32'h00000115);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("wait", 3'h5, rd[2:0])
    pattern_en <= 1'b1;
    repeat (5) @(posedge clk_sys);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("gated", 3'h5, rd[2:0])
    frame_en <= 1'b1;
    wait_meas(1'b1);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("run", 3'h3, rd[2:0])
    bus(ADDR_CONTROL, 1'b1, 32'h00000215);
    wait_meas(1'b0);
    `CHK("stop", 1'b0, measuring)
  endtask : sync_gate

  task automatic monitor_run;
    logic [31:0] es;
    pattern_en <= 1'b0;
    bus(ADDR_CONTROL, 1'b1, 32'h00000101);
    wait_meas(1'b1);
    `CHK("frame only", 1'b1, measuring)
    bus(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("na", 2'h3, rd[4:3])
    err_en <= 1'b1;
    repeat (40) @(posedge clk_sys);
    err_en <= 1'b0;
    repeat (40) @(posedge clk_sys);
    bus(ADDR_ERR_SEC, 1'b0, 32'h0);
    es = rd;
    `CHK("es", 1'b1, es != 32'h0 && es < 32'h7)
    bus(ADDR_EF_SEC, 1'b0, 32'h0);
    `CHK("efs", 1'b1, rd != 32'h0 && rd < 32'h7)
    bus(ADDR_CONTROL, 1'b1, 32'h00000104);
    bus(ADDR_ERR_SEC, 1'b0, 32'h0);
    `CHK("es clear", 32'h0, rd)
    wait_meas(1'b1);
    `CHK("loop frame", 1'b1, measuring)
    bus(ADDR_CONTROL, 1'b1, 32'h00000006);
    wait_meas(1'b0);
    `CHK("dis stop", 1'b0, measuring)
    `CHK("dis thru", 1'b1, through_transmission)
  endtask : monitor_run

  task automatic timeout_run;
    int i;
    bus(ADDR_TIMEOUT, 1'b1, 32'h00000001);
    bus(ADDR_CONTROL, 1'b1, 32'h00000001);
    bus(ADDR_TIME, 1'b0, 32'h0);
    `CHK("reload", 12'h801, rd[11:0])
    for (i = 0; i < 700 && access_mode !== 3'h0; i++) @(posedge clk_sys);
    `CHK("expire", 3'h0, access_mode)
    bus(ADDR_TIMEOUT, 1'b1, 32'h00000000);
    bus(ADDR_CONTROL, 1'b1, 32'h00000001);
    repeat (1300) @(posedge clk_sys);
    `CHK("no expire", 3'h1, access_mode)
    bus(ADDR_CONTROL, 1'b1, 32'h00000000);
  endtask : timeout_run

  task automatic results;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #200000;
    n_fail++;
    results();
  end

  initial
  begin
    n_fail = 0;
    num_checks = 0;
    reset = 1'b1;
    {hsel, hwrite, frame_en, pattern_en, err_en} = 5'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    reset_values();
    sync_gate();
    monitor_run();
    timeout_run();
    results();
  end
endmodule : tb_test_session_ctrl
`default_nettype wire
